// >>> rtl/acc_pkg.sv
package acc_pkg;
  // register byte offsets
  localparam logic [5:0] SETUP1_OFS   = 6'h00;
  localparam logic [5:0] SETUP2_OFS   = 6'h04;
  localparam logic [5:0] SETUP3_OFS   = 6'h08;
  localparam logic [5:0] SETUP4_OFS   = 6'h0c;
  localparam logic [5:0] OFFSET_OFS   = 6'h10;
  localparam logic [5:0] GAIN_OFS     = 6'h1c;
  localparam logic [5:0] STATUS_OFS   = 6'h28;
  localparam logic [5:0] WORD_OFS     = 6'h2c;
  // reset values and writable masks
  localparam logic [7:0] SETUP1_RST   = 8'h03;
  localparam logic [7:0] SETUP2_RST   = 8'h23;
  localparam logic [7:0] SETUP3_RST   = 8'h1f;
  localparam logic [7:0] SETUP4_RST   = 8'h05;
  localparam logic [7:0] OFFSET_RST   = 8'h80;
  localparam logic [7:0] GAIN_RST     = 8'h00;
  localparam logic [7:0] SETUP1_MASK  = 8'h7f;
  localparam logic [7:0] SETUP2_MASK  = 8'hec;
  localparam logic [7:0] SETUP2_FIX   = 8'h03;
  localparam logic [7:0] SETUP3_MASK  = 8'h3f;
  localparam logic [7:0] SETUP4_MASK  = 8'h38;
  localparam logic [7:0] SETUP4_FIX   = 8'h05;
  // field positions
  localparam int S1_EN   = 0;
  localparam int S1_DS   = 1;
  localparam int S1_SEL  = 2;
  localparam int S1_TIE  = 3;
  localparam int S1_FS   = 4;
  localparam int S2_INV  = 2;
  localparam int S2_EXT  = 3;
  localparam int S2_RNG  = 5;
  localparam int S3_CODE = 0;
  localparam int S3_TIM  = 4;
  localparam int S4_CLMP = 3;
  localparam int S4_COL  = 4;
  // analogue levels as 16-bit codes, 1 V = 16384
  localparam logic [15:0] DAC_STEP_LO = 16'h0b85;
  localparam logic [15:0] DAC_BOT_LO  = 16'h1333;
  localparam logic [15:0] DAC_STEP_HI = 16'h07df;
  localparam logic [15:0] DAC_BOT_HI  = 16'h0ccd;
  localparam logic [7:0]  OFS_STEP    = 8'h21;
  localparam logic [11:0] GAIN_BASE   = 12'h0c8;
  localparam logic [11:0] GAIN_SLOPE  = 12'h792;
  localparam logic [16:0] ADC_MID     = 17'h07fff;
  localparam logic [16:0] ADC_TOP     = 17'h0ffff;
  localparam logic [2:0]  REF_DELAY   = 3'h1;
  typedef enum logic [1:0] {
    ACC_RED   = 2'b00,
    ACC_GREEN = 2'b01,
    ACC_BLUE  = 2'b10,
    ACC_RSVD  = 2'b11
  } acc_colour_t;
endpackage

// >>> rtl/acc_sample_proc.sv
`timescale 1ns/10ps
module acc_sample_proc (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic [15:0]       video,
  input  wire logic [15:0]       ref_level,
  input  wire logic [7:0]        offset,
  input  wire logic [7:0]        gain,
  input  wire logic [1:0]        placement,
  input  wire logic              invert,
  output logic [15:0]            word,
  output logic                   valid
);
  typedef struct packed {
    logic               v1;
    logic signed [19:0] v2;
    logic [11:0]        g;
    logic [1:0]         fs;
    logic               inv;
    logic               v;
    logic [15:0]        w;
  } acc_proc_t;
  acc_proc_t r_reg, r_next;
  logic signed [31:0] prod;
  logic signed [31:0] d1;
  logic [19:0]        gm;

  always_comb begin
    r_next = r_reg;
    gm = 20'(gain) * 20'(acc_pkg::GAIN_SLOPE);
    prod = 32'(r_reg.v2) * $signed({20'h0, r_reg.g});
    d1 = (prod >>> 7);
    r_next.v1 = start;
    r_next.fs = placement;
    r_next.inv = invert;
    // offset centred on half a code; gain in 1/256 steps
    r_next.v2 = 20'($signed({4'h0, video}) - $signed({4'h0, ref_level}))
              + 20'(($signed({12'h0, offset, 1'b0}) - 20'sd255)
              * $signed({12'h0, acc_pkg::OFS_STEP}) >>> 1);
    r_next.g = acc_pkg::GAIN_BASE + 12'(gm >> 8);
    r_next.v = r_reg.v1;
    if (r_reg.v1) begin
      case (r_reg.fs)
        2'b10:   d1 = d1 + 32'(acc_pkg::ADC_TOP);
        2'b11:   d1 = d1;
        default: d1 = d1 + 32'(acc_pkg::ADC_MID);
      endcase
      if (d1 < 0)
        d1 = 0;
      else if (d1 > 32'(acc_pkg::ADC_TOP))
        d1 = 32'(acc_pkg::ADC_TOP);
      r_next.w = r_reg.inv ? 16'hffff - d1[15:0] : d1[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign word = r_reg.w;
  assign valid = r_reg.v;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_invert;
    r_reg.v1 && r_reg.inv && r_reg.fs == 2'b11 && r_reg.v2 <= 0
      |=> word == 16'hffff;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverted black level not full scale");
  property p_top;
    r_reg.v1 && !r_reg.inv && r_reg.fs == 2'b10 && r_reg.v2 >= 0
      |=> word == 16'hffff;
  endproperty
  a_top: assert property (p_top)
    else $error("zero input not at converter top");
  property p_latency;
    start |-> ##2 valid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("processed word missing two cycles after sample");
endmodule

// >>> rtl/acc_nibble_tx.sv
`timescale 1ns/10ps
module acc_nibble_tx (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] word,
  output logic [3:0]       nibble,
  output logic             first
);
  typedef struct packed {
    logic [11:0] rest;
    logic [1:0]  left;
    logic [3:0]  nib;
    logic        fst;
  } acc_tx_t;
  acc_tx_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.fst = 1'b0;
    if (load) begin
      r_next.nib = word[15:12];
      r_next.rest = word[11:0];
      r_next.left = 2'h3;
      r_next.fst = 1'b1;
    end else if (r_reg.left != 2'h0) begin
      r_next.nib = r_reg.rest[11:8];
      r_next.rest = {r_reg.rest[7:0], 4'h0};
      r_next.left = r_reg.left - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign nibble = r_reg.nib;
  assign first = r_reg.fst;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_order;
    load ##1 !load [*3]
      |=> nibble == $past(word[3:0], 4)
       && $past(nibble) == $past(word[7:4], 4);
  endproperty
  a_order: assert property (p_order)
    else $error("nibble order wrong");
endmodule

// >>> rtl/acc_afe_channel_control.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - input select bit picks input a or b
// - tie bit joins both video inputs
// - reserved colour code keeps the last coefficient set
// - colour code picks red, green, blue pair
// - separate 8-bit offset and gain per colour
// - clamp request captured during sample pulse
// - captured level gates next clamp pulse
// - clamp pulse switches node to reference
// - timing field places clamp and reset sample
// - 4-bit code drives dac, range bit narrows it
// - external bit disables dac for pin voltage
// - double sampling references reset level
// - reset sampled before video, then subtracted
// - single sampling uses dac level, or pin voltage if external
// - dac level is step times code plus base
// - placement field sets zero input position
// - sample becomes 16-bit word, 4-bit bus
// - invert bit gives full scale minus word
// - four nibbles sent most significant first
module acc_afe_channel_control (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        SAMPLE_PULSE,
  input  wire logic [15:0] VIDEO_INPUT_A,
  input  wire logic [15:0] VIDEO_INPUT_B,
  input  wire logic [15:0] CLAMP_BIAS_PIN_IN,
  output logic [15:0]      CLAMP_BIAS_PIN_OUT,
  output logic             CLAMP_BIAS_PIN_OE,
  output logic             CLAMP_PULSE,
  output logic             INPUT_TIE,
  output logic [3:0]       NIBBLE_OUTPUT_BUS,
  output logic             NIBBLE_FIRST,
  input  wire logic [5:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [5:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  typedef struct packed {
    logic [1:0]       sp_s;
    logic             sp_d;
    logic [1:0][15:0] va_s;
    logic [1:0][15:0] vb_s;
    logic [1:0][15:0] bias_s;
    logic [7:0]       s1;
    logic [7:0]       s2;
    logic [7:0]       s3;
    logic [7:0]       s4;
    logic [2:0][7:0]  offs;
    logic [2:0][7:0]  gains;
    logic [7:0]       cur_off;
    logic [7:0]       cur_gain;
    logic [1:0]       cur_col;
    logic             clamp_cap;
    logic             pend;
    logic [2:0]       cnt;
    logic             clamp;
    logic [15:0]      reset_lvl;
    logic [15:0]      dac_out;
    logic             dac_oe;
    logic             tie;
    logic             aw_full;
    logic [5:0]       aw_addr;
    logic             w_full;
    logic [7:0]       w_byte;
    logic             w_en;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [15:0]      last_word;
  } acc_state_t;
  acc_state_t r_reg, r_next;

  logic        rise;
  logic        fall;
  logic [15:0] vid_now;
  logic [15:0] ref_now;
  logic [15:0] dac_lvl;
  logic        start;
  logic [15:0] word;
  logic        word_v;
  logic [7:0]  wb;

  acc_sample_proc u_proc (
    .clk       (MCLK),
    .rst       (RESET),
    .start     (start),
    .video     (vid_now),
    .ref_level (ref_now),
    .offset    (r_reg.cur_off),
    .gain      (r_reg.cur_gain),
    .placement (r_reg.s1[acc_pkg::S1_FS +: 2]),
    .invert    (r_reg.s2[acc_pkg::S2_INV]),
    .word      (word),
    .valid     (word_v)
  );

  acc_nibble_tx u_tx (
    .clk    (MCLK),
    .rst    (RESET),
    .load   (word_v),
    .word   (word),
    .nibble (NIBBLE_OUTPUT_BUS),
    .first  (NIBBLE_FIRST)
  );

  always_comb begin
    rise = r_reg.sp_s[1] && !r_reg.sp_d;
    fall = !r_reg.sp_s[1] && r_reg.sp_d;
    start = fall && r_reg.s1[acc_pkg::S1_EN];
    if (r_reg.s1[acc_pkg::S1_TIE])
      vid_now = 16'((17'(r_reg.va_s[1]) + 17'(r_reg.vb_s[1])) >> 1);
    else if (r_reg.s1[acc_pkg::S1_SEL])
      vid_now = r_reg.vb_s[1];
    else
      vid_now = r_reg.va_s[1];
    if (r_reg.s2[acc_pkg::S2_RNG])
      dac_lvl = 16'(r_reg.s3[3:0] * acc_pkg::DAC_STEP_HI)
              + acc_pkg::DAC_BOT_HI;
    else
      dac_lvl = 16'(r_reg.s3[3:0] * acc_pkg::DAC_STEP_LO)
              + acc_pkg::DAC_BOT_LO;
    if (r_reg.s1[acc_pkg::S1_DS])
      ref_now = r_reg.reset_lvl;
    else if (r_reg.s2[acc_pkg::S2_EXT])
      ref_now = r_reg.bias_s[1];
    else
      ref_now = r_reg.dac_out;
  end

  always_comb begin
    r_next = r_reg;
    wb = r_reg.w_byte;
    r_next.sp_s = {r_reg.sp_s[0], SAMPLE_PULSE};
    r_next.sp_d = r_reg.sp_s[1];
    r_next.va_s = {r_reg.va_s[0], VIDEO_INPUT_A};
    r_next.vb_s = {r_reg.vb_s[0], VIDEO_INPUT_B};
    r_next.bias_s = {r_reg.bias_s[0], CLAMP_BIAS_PIN_IN};
    r_next.clamp = 1'b0;
    r_next.tie = r_reg.s1[acc_pkg::S1_TIE];
    if (word_v)
      r_next.last_word = word;
    r_next.dac_out = dac_lvl;
    r_next.dac_oe = !r_reg.s2[acc_pkg::S2_EXT];
    if (rise) begin
      r_next.clamp_cap = r_reg.s4[acc_pkg::S4_CLMP];
      if (r_reg.s4[acc_pkg::S4_COL +: 2] != acc_pkg::ACC_RSVD) begin
        r_next.cur_col = r_reg.s4[acc_pkg::S4_COL +: 2];
        r_next.cur_off = r_reg.offs[r_reg.s4[acc_pkg::S4_COL +: 2]];
        r_next.cur_gain = r_reg.gains[r_reg.s4[acc_pkg::S4_COL +: 2]];
      end
    end
    if (fall) begin
      r_next.pend = 1'b1;
      r_next.cnt = r_reg.s3[acc_pkg::S3_TIM +: 2] + acc_pkg::REF_DELAY;
    end else if (r_reg.pend && r_reg.cnt != 3'h0) begin
      r_next.cnt = r_reg.cnt - 3'h1;
    end else if (r_reg.pend) begin
      r_next.pend = 1'b0;
      r_next.reset_lvl = vid_now;
      if (r_reg.clamp_cap) begin
        r_next.clamp = 1'b1;
        r_next.reset_lvl = r_reg.s2[acc_pkg::S2_EXT] ? r_reg.bias_s[1]
                                                     : r_reg.dac_out;
      end
    end
    // write channel: address and data in either order
    if (S_AXI_AWVALID && r_reg.awready) begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r_reg.wready) begin
      r_next.w_full = 1'b1;
      r_next.w_byte = S_AXI_WDATA[7:0];
      r_next.w_en = S_AXI_WSTRB[0];
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
      r_next.bvalid = 1'b0;
    if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
      r_next.aw_full = 1'b0;
      r_next.w_full = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = 2'b00;
      case (r_reg.aw_addr)
        acc_pkg::SETUP1_OFS: if (r_reg.w_en)
          r_next.s1 = wb & acc_pkg::SETUP1_MASK;
        acc_pkg::SETUP2_OFS: if (r_reg.w_en)
          r_next.s2 = (wb & acc_pkg::SETUP2_MASK) | acc_pkg::SETUP2_FIX;
        acc_pkg::SETUP3_OFS: if (r_reg.w_en)
          r_next.s3 = wb & acc_pkg::SETUP3_MASK;
        acc_pkg::SETUP4_OFS: if (r_reg.w_en)
          r_next.s4 = (wb & acc_pkg::SETUP4_MASK) | acc_pkg::SETUP4_FIX;
        6'h10, 6'h14, 6'h18: if (r_reg.w_en)
          r_next.offs[2'(r_reg.aw_addr[5:2] - 4'h4)] = wb;
        6'h1c, 6'h20, 6'h24: if (r_reg.w_en)
          r_next.gains[2'(r_reg.aw_addr[5:2] - 4'h7)] = wb;
        acc_pkg::STATUS_OFS, acc_pkg::WORD_OFS: ;
        default: r_next.bresp = 2'b10;
      endcase
    end
    r_next.awready = !r_next.aw_full;
    r_next.wready = !r_next.w_full;
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      r_next.rvalid = 1'b0;
      r_next.arready = 1'b1;
    end
    if (S_AXI_ARVALID && r_reg.arready) begin
      r_next.arready = 1'b0;
      r_next.rvalid = 1'b1;
      r_next.rresp = 2'b00;
      r_next.rdata = 32'h0;
      case (S_AXI_ARADDR)
        acc_pkg::SETUP1_OFS: r_next.rdata[7:0] = r_reg.s1;
        acc_pkg::SETUP2_OFS: r_next.rdata[7:0] = r_reg.s2;
        acc_pkg::SETUP3_OFS: r_next.rdata[7:0] = r_reg.s3;
        acc_pkg::SETUP4_OFS: r_next.rdata[7:0] = r_reg.s4;
        6'h10, 6'h14, 6'h18:
          r_next.rdata[7:0] = r_reg.offs[2'(S_AXI_ARADDR[5:2] - 4'h4)];
        6'h1c, 6'h20, 6'h24:
          r_next.rdata[7:0] = r_reg.gains[2'(S_AXI_ARADDR[5:2] - 4'h7)];
        acc_pkg::STATUS_OFS:
          r_next.rdata[3:0] = {r_reg.pend, r_reg.clamp_cap, r_reg.cur_col};
        acc_pkg::WORD_OFS:   r_next.rdata[15:0] = r_reg.last_word;
        default:             r_next.rresp = 2'b10;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      r_reg <= '0;
      r_reg.s1 <= acc_pkg::SETUP1_RST;
      r_reg.s2 <= acc_pkg::SETUP2_RST;
      r_reg.s3 <= acc_pkg::SETUP3_RST;
      r_reg.s4 <= acc_pkg::SETUP4_RST;
      r_reg.offs <= {3{acc_pkg::OFFSET_RST}};
      r_reg.gains <= {3{acc_pkg::GAIN_RST}};
      r_reg.cur_off <= acc_pkg::OFFSET_RST;
      r_reg.cur_gain <= acc_pkg::GAIN_RST;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
      r_reg.arready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign CLAMP_BIAS_PIN_OUT = r_reg.dac_out;
  assign CLAMP_BIAS_PIN_OE  = r_reg.dac_oe;
  assign CLAMP_PULSE        = r_reg.clamp;
  assign INPUT_TIE          = r_reg.tie;
  assign S_AXI_AWREADY      = r_reg.awready;
  assign S_AXI_WREADY       = r_reg.wready;
  assign S_AXI_BVALID       = r_reg.bvalid;
  assign S_AXI_BRESP        = r_reg.bresp;
  assign S_AXI_ARREADY      = r_reg.arready;
  assign S_AXI_RVALID       = r_reg.rvalid;
  assign S_AXI_RDATA        = r_reg.rdata;
  assign S_AXI_RRESP        = r_reg.rresp;

  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  property p_capture;
    rise |=> r_reg.clamp_cap == $past(r_reg.s4[acc_pkg::S4_CLMP]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("clamp request not captured at sample pulse");
  property p_gate;
    CLAMP_PULSE |-> r_reg.clamp_cap || $past(rise);
  endproperty
  a_gate: assert property (p_gate)
    else $error("clamp pulse without captured request");
  property p_hold;
    !rise |=> $stable(r_reg.cur_off) && $stable(r_reg.cur_gain);
  endproperty
  a_hold: assert property (p_hold)
    else $error("coefficients changed inside a pixel");
  property p_green;
    rise && r_reg.s4[acc_pkg::S4_COL +: 2] == 2'b01
      |=> r_reg.cur_gain == $past(r_reg.gains[1]);
  endproperty
  a_green: assert property (p_green)
    else $error("green code did not pick green gain");
  property p_ext;
    r_reg.s2[acc_pkg::S2_EXT] [*2] |-> !CLAMP_BIAS_PIN_OE;
  endproperty
  a_ext: assert property (p_ext)
    else $error("reference dac still drives pin");
  property p_sel;
    !r_reg.s1[acc_pkg::S1_TIE] && !r_reg.s1[acc_pkg::S1_SEL]
      |-> vid_now == r_reg.va_s[1];
  endproperty
  a_sel: assert property (p_sel)
    else $error("input a not routed by default");
  property p_resetpos;
    fall && r_reg.s3[5:4] == 2'b00
      |-> ##3 !r_reg.pend && $past(r_reg.pend);
  endproperty
  a_resetpos: assert property (p_resetpos)
    else $error("reset sample late for timing code zero");
  property p_noref;
    start && !r_reg.s1[acc_pkg::S1_DS] && !r_reg.s2[acc_pkg::S2_EXT]
      |-> ref_now == r_reg.dac_out;
  endproperty
  a_noref: assert property (p_noref)
    else $error("single sampling not using dac level");
endmodule

// >>> verification/acc_sensor_model.sv
`timescale 1ns/10ps
module acc_sensor_model #(
  parameter int PERIOD = 20
) (
  input  wire logic        clk,
  input  wire logic [15:0] level_a,
  input  wire logic [15:0] level_b,
  input  wire logic [15:0] ext_level,
  input  wire logic [15:0] dac_level,
  input  wire logic        dac_oe,
  output logic             sample_pulse,
  output logic [15:0]      video_a,
  output logic [15:0]      video_b,
  output logic [15:0]      pin_level
);
  int phase = 0;

  initial begin
    sample_pulse = 1'b0;
    video_a = 16'h0000;
    video_b = 16'h0000;
  end

  // two-cycle pulse survives the design's input synchroniser
  always @(posedge clk) begin
    phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    sample_pulse <= (phase < 2);
    video_a <= level_a;
    video_b <= level_b;
  end

  // external source only once dac lets go
  assign pin_level = dac_oe ? dac_level : ext_level;
endmodule

// >>> verification/acc_afe_channel_control_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) begin \
      failures++; \
      $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); \
    end \
  end
module acc_afe_channel_control_tb_top;
  localparam logic [7:0] RV [10] = '{acc_pkg::SETUP1_RST,
    acc_pkg::SETUP2_RST, acc_pkg::SETUP3_RST, acc_pkg::SETUP4_RST,
    8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  logic        MCLK = 1'b0;
  logic        RESET = 1'b1;
  logic [15:0] lvl_a = 16'h0, lvl_b = 16'h0, ext_lvl = 16'h0;
  logic [5:0]  aw_addr = 6'h0, ar_addr = 6'h0;
  logic [31:0] w_data = 32'h0;
  logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
  logic        ar_valid = 1'b0, r_ready = 1'b0;
  wire logic   aw_ready, w_ready, b_valid, ar_ready, r_valid;
  wire logic [1:0]  b_resp, r_resp;
  wire logic [31:0] r_data;
  wire logic [15:0] va, vb, pin_in, pin_out;
  wire logic        oe, clamp, tie, first, sp;
  wire logic [3:0]  nib;
  logic [15:0] acc_w = 16'h0, head;
  logic [15:0] expq [$];
  int          ncap = 0, failures = 0, n_tests = 0;

  acc_sensor_model #(.PERIOD(20)) sensor (
    .clk(MCLK), .level_a(lvl_a), .level_b(lvl_b), .ext_level(ext_lvl),
    .dac_level(pin_out), .dac_oe(oe), .sample_pulse(sp), .video_a(va),
    .video_b(vb), .pin_level(pin_in));

  acc_afe_channel_control DUT (
    .MCLK(MCLK), .RESET(RESET), .SAMPLE_PULSE(sp),
    .VIDEO_INPUT_A(va), .VIDEO_INPUT_B(vb), .CLAMP_BIAS_PIN_IN(pin_in),
    .CLAMP_BIAS_PIN_OUT(pin_out), .CLAMP_BIAS_PIN_OE(oe),
    .CLAMP_PULSE(clamp), .INPUT_TIE(tie), .NIBBLE_OUTPUT_BUS(nib),
    .NIBBLE_FIRST(first), .S_AXI_AWADDR(aw_addr),
    .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
    .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
    .S_AXI_RREADY(r_ready));

  initial begin
    forever #4 MCLK = ~MCLK;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int k;
    @(posedge MCLK);
    aw_addr <= a;
    w_data <= {24'h0, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge MCLK);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid) break;
    end
    bound(k, 64);
    b_ready <= 1'b0;
    `CHK(b_resp, er)
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int k;
    @(posedge MCLK);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge MCLK);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid) break;
    end
    bound(k, 64);
    r_ready <= 1'b0;
    `CHK(r_resp, er)
    if (er == 2'b00) `CHK(r_data, ed)
  endtask

  // settle through words already in flight, then expect two alike
  task automatic expect_word(input logic [15:0] e);
    int k;
    repeat (80) @(posedge MCLK);
    expq.push_back(e);
    expq.push_back(e);
    for (k = 0; k < 200 && expq.size() > 0; k++) @(posedge MCLK);
    bound(k, 200);
  endtask

  task automatic count_clamps(output int n);
    n = 0;
    repeat (40) @(posedge MCLK);
    repeat (200) begin
      @(posedge MCLK);
      if (clamp === 1'b1) n++;
    end
  endtask

  always @(posedge MCLK) begin
    if (first === 1'b1) begin
      acc_w = {12'h0, nib};
      ncap = 1;
    end else if (ncap > 0) begin
      acc_w = {acc_w[11:0], nib};
      ncap++;
    end
    if (ncap == 4) begin
      ncap = 0;
      if (expq.size() > 0) begin
        head = expq.pop_front();
        `CHK(acc_w, head)
      end
    end
  end

  initial begin
    int          i, n;
    logic [15:0] rl, d, e;
    logic [3:0]  code;
    void'($urandom(79788));
    rl = 16'h4000 + 16'($urandom % 16384);
    d = 16'h1333 + 16'($urandom % 8192);
    ext_lvl <= rl;
    lvl_a <= rl + d;
    lvl_b <= rl - d;
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    for (i = 0; i < 10; i++) rd(6'(4 * i), {24'h0, RV[i]}, 2'b00);
    rd(6'h30, 32'h0, 2'b10);
    wr(6'h30, 8'h00, 2'b10);
    wr(acc_pkg::SETUP2_OFS, 8'h00, 2'b00);
    rd(acc_pkg::SETUP2_OFS, {24'h0, acc_pkg::SETUP2_FIX}, 2'b00);
    for (i = 0; i < 3; i++) wr(acc_pkg::GAIN_OFS + 6'(4 * i), 8'hff, 2'b00);
    $display("test registers done");
    // saturating input: sign and invert bit alone fix the word, any placement
    for (i = 0; i < 16; i++) begin
      wr(acc_pkg::SETUP1_OFS, {2'b00, 2'(i >> 1), 1'b0, i[0], 2'b01}, 2'b00);
      wr(acc_pkg::SETUP2_OFS, {5'h01, i[3], 2'b11}, 2'b00);
      if (i == 0) begin
        // enable register trails the setup write by one edge
        @(posedge MCLK);
        `CHK(oe, 1'b0)
      end
      expect_word((i[0] ^ i[3]) ? 16'h0000 : 16'hffff);
    end
    $display("test select, placement, invert done");
    lvl_a <= rl;
    wr(acc_pkg::SETUP1_OFS, 8'h31, 2'b00);
    wr(acc_pkg::SETUP2_OFS, 8'h0b, 2'b00);
    wr(acc_pkg::OFFSET_OFS, 8'h00, 2'b00);
    wr(acc_pkg::OFFSET_OFS + 6'h04, 8'hff, 2'b00);
    wr(acc_pkg::OFFSET_OFS + 6'h08, 8'h00, 2'b00);
    // one colour write per line, red green blue
    for (i = 0; i < 3; i++) begin
      wr(acc_pkg::SETUP4_OFS, {2'b00, 2'(i), 4'h5}, 2'b00);
      expect_word((i == 1) ? 16'hffff : 16'h0000);
    end
    $display("test colour done");
    lvl_a <= rl - d;
    // green offset lifts cds result above black, non-cds stays below
    wr(acc_pkg::SETUP4_OFS, 8'h15, 2'b00);
    wr(acc_pkg::SETUP1_OFS, 8'h33, 2'b00);
    expect_word(16'hffff);
    wr(acc_pkg::SETUP1_OFS, 8'h31, 2'b00);
    expect_word(16'h0000);
    $display("test double sampling done");
    wr(acc_pkg::SETUP4_OFS, 8'h0d, 2'b00);
    for (i = 0; i < 4; i++) begin
      wr(acc_pkg::SETUP3_OFS, {2'b00, 2'(i), 4'hf}, 2'b00);
      count_clamps(n);
      `CHK(n >= 9 && n <= 11, 1'b1)
    end
    wr(acc_pkg::SETUP4_OFS, 8'h05, 2'b00);
    count_clamps(n);
    `CHK(n, 0)
    $display("test clamp done");
    for (i = 0; i < 6; i++) begin
      code = (i < 2) ? 4'h0 : (i < 4) ? 4'hf : 4'($urandom % 16);
      wr(acc_pkg::SETUP2_OFS, {2'b00, i[0], 5'b00011}, 2'b00);
      wr(acc_pkg::SETUP3_OFS, {4'h1, code}, 2'b00);
      e = i[0] ? acc_pkg::DAC_STEP_HI * {12'h0, code} + acc_pkg::DAC_BOT_HI
               : acc_pkg::DAC_STEP_LO * {12'h0, code} + acc_pkg::DAC_BOT_LO;
      repeat (4) @(posedge MCLK);
      `CHK(oe, 1'b1)
      `CHK(pin_out, e)
    end
    $display("test reference dac done");
    wr(acc_pkg::SETUP1_OFS, 8'h39, 2'b00);
    repeat (4) @(posedge MCLK);
    `CHK(tie, 1'b1)
    wr(acc_pkg::SETUP1_OFS, 8'h31, 2'b00);
    repeat (4) @(posedge MCLK);
    `CHK(tie, 1'b0)
    $display("test tie done");
    tally_and_finish();
  end
endmodule
